// ---- shared/pasout_pkg.sv ----
// Constants and carrier types for the pipelined converter output block.
// Assumes one 125 MHz core clock; all counts are in core clock cycles.
package pasout_pkg;

	// Sample word
	localparam int          CODE_BITS      = 12;
	localparam int          IN_BITS        = 13;
	localparam int          DIFF_BITS      = 15;
	localparam logic [11:0] CODE_NEG_FULL  = 12'h000;
	localparam logic [11:0] CODE_QUARTER   = 12'h400;
	localparam logic [11:0] CODE_MIDSCALE  = 12'h800;
	localparam logic [11:0] CODE_3QUARTER  = 12'hC00;
	localparam logic [11:0] CODE_POS_FULL  = 12'hFFF;

	// Timing in sample clock cycles
	localparam int          PIPE_LATENCY   = 6;
	localparam int          PIPE_STAGES    = PIPE_LATENCY - 1;
	localparam int          WAKE_CYCLES    = 20;
	localparam int          WAKE_BITS      = 5;
	localparam int          FIFO_DEPTH     = 16;

	// Reset values
	localparam logic [11:0] RST_CODE       = 12'h000;
	localparam logic [4:0]  RST_WAKE       = 5'h00;

	typedef struct packed {
		logic                 valid;
		logic                 clip;
		logic [CODE_BITS-1:0] code;
	} pasout_word_t;

	localparam int WORD_BITS = $bits(pasout_word_t);

endpackage

// ---- verilog/pasout_top.sv ----
// Output side of a 12-bit pipelined converter, with its data FIFO.
// Analog pins arrive as quantised levels relative to common mode,
// in LSB units where one reference voltage equals 2048 LSB.
// Pins are asynchronous to core_clk and pass two flip-flops first.
//
// Behaviour
// - A new sample of the differential input is taken every clock.
// - Each word reaches the output pins six edges after its sample.
// - One word leaves per clock, the word rate equals the clock.
// - Each output word is twelve bits wide.
// - Differential drive is coded offset binary from 000 to FFF.
// - Single-ended drive needs a full reference swing for end codes.
// - The 2047 to 2048 step falls at zero differential input.
// - Words flow every cycle; power-down clears the words still in the stages.
// - Every one of the 4096 codes can be produced.
// - A high power-down request stops conversion while it lasts.
// - Output enable high floats the data pins, conversion goes on.
`timescale 1ns/100ps

module pasout_fifo
	import pasout_pkg::*;
#(
	parameter int WIDTH = WORD_BITS,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PTR_BITS = $clog2(DEPTH);
	localparam int CNT_BITS = $clog2(DEPTH + 1);
	localparam logic [CNT_BITS-1:0] FULL_CNT = CNT_BITS'(DEPTH);
	localparam logic [PTR_BITS-1:0] LAST_PTR = PTR_BITS'(DEPTH - 1);

	logic [WIDTH-1:0]    mem_ff [DEPTH];
	logic [PTR_BITS-1:0] wrPtr_ff;
	logic [PTR_BITS-1:0] rdPtr_ff;
	logic [CNT_BITS-1:0] count_ff;
	logic [PTR_BITS-1:0] nxt_wrPtr;
	logic [PTR_BITS-1:0] nxt_rdPtr;
	logic [CNT_BITS-1:0] nxt_count;
	wire                 doWrite;
	wire                 doRead;

	assign inReady  = (count_ff != FULL_CNT);
	assign outValid = (count_ff != '0);
	// Show-ahead read so a lone word costs one cycle
	assign outData  = mem_ff[rdPtr_ff];
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;

	assign nxt_wrPtr = (wrPtr_ff == LAST_PTR) ? '0 : wrPtr_ff + 1'b1;
	assign nxt_rdPtr = (rdPtr_ff == LAST_PTR) ? '0 : rdPtr_ff + 1'b1;
	assign nxt_count = count_ff + CNT_BITS'(doWrite) - CNT_BITS'(doRead);

	always_ff @(posedge core_clk) begin
		if (doWrite) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_ff <= nxt_wrPtr;
			end
			if (doRead) begin
				rdPtr_ff <= nxt_rdPtr;
			end
			count_ff <= nxt_count;
		end
	end

endmodule

module pasout_top
	import pasout_pkg::*;
#(
	parameter int LATENCY    = PIPE_LATENCY,
	parameter int FIFO_WORDS = FIFO_DEPTH,
	parameter int WAKE_CLKS  = WAKE_CYCLES
) (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_b,
	// Analog pins, quantised, relative to common mode
	input  wire logic signed [IN_BITS-1:0] analogInPos,
	input  wire logic signed [IN_BITS-1:0] analogInNeg,
	// Control pins
	input  wire logic                      lowPowerRequest,
	input  wire logic                      outEnable_b,
	// Data pins
	output logic           [CODE_BITS-1:0] sampleData,
	output logic                           sampleDataOe,
	// Status
	output logic                           wordValid,
	output logic                           overRange,
	output logic                           powerDownActive,
	output logic                           wakeDone
);
	localparam int STAGES = LATENCY - 1;
	localparam logic [WAKE_BITS-1:0] WAKE_LAST = WAKE_BITS'(WAKE_CLKS - 1);
	localparam logic signed [DIFF_BITS-1:0] MID_OFS =
		DIFF_BITS'(CODE_MIDSCALE);
	localparam logic signed [DIFF_BITS-1:0] TOP_CODE =
		DIFF_BITS'(CODE_POS_FULL);

	// Clamp to the code range; both ends reachable, none missing
	function automatic pasout_word_t toOffsetBinary(
		input logic signed [IN_BITS-1:0] pos,
		input logic signed [IN_BITS-1:0] neg
	);
		logic signed [DIFF_BITS-1:0] lvl;
		pasout_word_t w;
		lvl = DIFF_BITS'(pos) - DIFF_BITS'(neg) + MID_OFS;
		w.valid = 1'b1;
		w.clip  = 1'b0;
		if (lvl < 0) begin
			w.code = CODE_NEG_FULL;
			w.clip = 1'b1;
		end else if (lvl > TOP_CODE) begin
			w.code = CODE_POS_FULL;
			w.clip = 1'b1;
		end else begin
			w.code = lvl[CODE_BITS-1:0];
		end
		return w;
	endfunction

	// Pin synchronisers
	logic signed [IN_BITS-1:0] posMeta_ff;
	logic signed [IN_BITS-1:0] posSync_ff;
	logic signed [IN_BITS-1:0] negMeta_ff;
	logic signed [IN_BITS-1:0] negSync_ff;
	logic                      pdMeta_ff;
	logic                      pdSync_ff;
	logic                      oeMeta_ff;
	logic                      oeSync_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			posMeta_ff <= '0;
			posSync_ff <= '0;
			negMeta_ff <= '0;
			negSync_ff <= '0;
		end else begin
			posMeta_ff <= analogInPos;
			posSync_ff <= posMeta_ff;
			negMeta_ff <= analogInNeg;
			negSync_ff <= negMeta_ff;
		end
	end

	// Power-down assumed at reset until the pin is seen low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pdMeta_ff <= 1'b1;
			pdSync_ff <= 1'b1;
			oeMeta_ff <= 1'b1;
			oeSync_ff <= 1'b1;
		end else begin
			pdMeta_ff <= lowPowerRequest;
			pdSync_ff <= pdMeta_ff;
			oeMeta_ff <= outEnable_b;
			oeSync_ff <= oeMeta_ff;
		end
	end

	// Pipeline stages; stage 0 is the sampling edge
	pasout_word_t stage_ff [STAGES];
	pasout_word_t sampled;
	pasout_word_t fifoOut;
	wire          fifoInReady;
	wire          fifoOutValid;
	wire          advance;
	wire          drain;
	logic         pdActive_ff;

	assign sampled = toOffsetBinary(posSync_ff, negSync_ff);
	// Stall on a full FIFO keeps data but breaks fixed latency
	assign advance = !pdSync_ff && fifoInReady;
	// Drain one edge past entry, else a stale word leaks out on wake
	assign drain   = !pdActive_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_ff[0] <= '0;
		end else if (pdSync_ff) begin
			stage_ff[0] <= '0;
		end else if (advance) begin
			stage_ff[0] <= sampled;
		end
	end

	for (genvar i = 1; i < STAGES; i++) begin : g_pipe
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				stage_ff[i] <= '0;
			end else if (pdSync_ff) begin
				stage_ff[i] <= '0;
			end else if (advance) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end

	// Last stage enters the FIFO, output register takes it next edge
	pasout_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.inValid  (stage_ff[STAGES-1].valid && advance),
		.inReady  (fifoInReady),
		.inData   (stage_ff[STAGES-1]),
		.outValid (fifoOutValid),
		.outReady (drain),
		.outData  (fifoOut)
	);

	// Wake-up count after power-down exit
	logic [WAKE_BITS-1:0] wake_ff;
	logic                 wakeDone_ff;
	wire                  wakeEnd;

	assign wakeEnd = (wake_ff == WAKE_LAST);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_ff     <= RST_WAKE;
			wakeDone_ff <= 1'b0;
		end else if (pdSync_ff) begin
			wake_ff     <= RST_WAKE;
			wakeDone_ff <= 1'b0;
		end else if (!wakeDone_ff) begin
			wake_ff     <= wakeEnd ? RST_WAKE : wake_ff + 1'b1;
			wakeDone_ff <= wakeEnd;
		end
	end

	// Output register; data keeps flowing even while floated
	logic [CODE_BITS-1:0] data_ff;
	logic                 oe_ff;
	logic                 valid_ff;
	logic                 clip_ff;
	wire                  take;

	assign take = fifoOutValid && drain;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_ff  <= RST_CODE;
			valid_ff <= 1'b0;
			clip_ff  <= 1'b0;
		end else if (take) begin
			data_ff  <= fifoOut.code;
			valid_ff <= fifoOut.valid;
			clip_ff  <= fifoOut.clip;
		end else begin
			valid_ff <= 1'b0;
			clip_ff  <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_ff       <= 1'b0;
			pdActive_ff <= 1'b1;
		end else begin
			oe_ff       <= !oeSync_ff;
			pdActive_ff <= pdSync_ff;
		end
	end

	assign sampleData      = data_ff;
	assign sampleDataOe    = oe_ff;
	assign wordValid       = valid_ff;
	assign overRange       = clip_ff;
	assign powerDownActive = pdActive_ff;
	assign wakeDone        = wakeDone_ff;

endmodule

// ---- tb/pasout_monitor.sv ----
// Checker for the converter output block.
// Assumes pins stay steady around each rising core_clk edge.
`timescale 1ns/100ps
module pasout_monitor
	import pasout_pkg::*;
#(parameter int WAKE_CLKS = WAKE_CYCLES) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Pins
	input wire logic signed [IN_BITS-1:0] analogInPos,
	input wire logic signed [IN_BITS-1:0] analogInNeg,
	input wire logic lowPowerRequest,
	input wire logic outEnable_b,
	input wire logic [CODE_BITS-1:0] sampleData,
	input wire logic sampleDataOe,
	// Status
	input wire logic wordValid,
	input wire logic overRange,
	input wire logic powerDownActive,
	input wire logic wakeDone
);
	logic [5:0] runCnt_ff;
	logic [2:0] rstCnt_ff;
	wire logic signed [DIFF_BITS-1:0] lvl = DIFF_BITS'(analogInPos)
		- DIFF_BITS'(analogInNeg) + 15'sh0800;
	wire logic clip = lvl < 0 || lvl > 15'sh0FFF;
	wire logic [11:0] expCode = lvl < 0 ? 12'h000 : lvl > 15'sh0FFF ?
		12'hFFF : lvl[11:0];
	wire logic [5:0] nxt_runCnt = powerDownActive ? 6'h00 :
		runCnt_ff + {5'h00, runCnt_ff != 6'h3F};
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			runCnt_ff <= 6'h00;
			rstCnt_ff <= 3'h0;
		end else begin
			runCnt_ff <= nxt_runCnt;
			rstCnt_ff <= rstCnt_ff + {2'h0, rstCnt_ff != 3'h7};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_code_latency: assert property (
		wordValid |-> sampleData == $past(expCode, 9)) else $error("bad code");
	chk_clip_flag: assert property (
		wordValid |-> overRange == $past(clip, 9)) else $error("bad clip");
	chk_oe_delay: assert property (
		rstCnt_ff == 3'h7 |-> sampleDataOe == !$past(outEnable_b, 3))
		else $error("bad enable");
	chk_steady_flow: assert property (
		runCnt_ff >= 6'h0C && !powerDownActive |-> wordValid)
		else $error("word missing");
	chk_wake_count: assert property (
		wakeDone == (!powerDownActive && runCnt_ff >= WAKE_CLKS - 1))
		else $error("bad wake");
	chk_stage_clear: assert property (
		$fell(powerDownActive) |-> !wordValid [*6]) else $error("stale word");
	chk_pd_hold: assert property (
		powerDownActive && $past(powerDownActive, 2) |->
		$stable(sampleData) && !wordValid) else $error("runs in sleep");
	chk_pd_entry: assert property (
		$rose(lowPowerRequest) |-> ##[2:3] powerDownActive)
		else $error("no sleep");
	cover property (wordValid && overRange);
	cover property ($fell(powerDownActive));
	cover property (!sampleDataOe && wordValid);
endmodule
bind pasout_top pasout_monitor #(.WAKE_CLKS(WAKE_CLKS)) u_pasout_monitor (
	.core_clk(core_clk), .rst_b(rst_b), .analogInPos(analogInPos),
	.analogInNeg(analogInNeg), .lowPowerRequest(lowPowerRequest),
	.outEnable_b(outEnable_b), .sampleData(sampleData),
	.sampleDataOe(sampleDataOe), .wordValid(wordValid),
	.overRange(overRange), .powerDownActive(powerDownActive),
	.wakeDone(wakeDone));

// ---- tb/pasout_capture.sv ----
// Capture logic model on the far side of the sample bus.
// Assumes it shares core_clk with the converter block.
`timescale 1ns/100ps
module pasout_capture
	import pasout_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Sample bus
	input wire logic [CODE_BITS-1:0] sampleData,
	input wire logic sampleDataOe,
	input wire logic wordValid,
	input wire logic wakeDone,
	// Captured words
	output logic [CODE_BITS-1:0] capWord_ff,
	output logic [15:0] capCount_ff
);
	// Floating pins read as noise, never as the last word
	wire logic [11:0] busLevel = sampleDataOe ? sampleData :
		~capWord_ff;
	wire logic take = wordValid && wakeDone && sampleDataOe;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			capWord_ff <= 12'h000;
			capCount_ff <= 16'h0000;
		end else if (take) begin
			capWord_ff <= busLevel;
			capCount_ff <= capCount_ff + 16'h0001;
		end
	end
endmodule

// ---- tb/tb_pasout_top.sv ----
// Testbench for the converter output block with a capture model.
// Assumes the checker binds itself to the block.
`timescale 1ns/100ps
module tb_pasout_top;
	import pasout_pkg::*;
	logic core_clk, rst_b, lowPowerRequest, outEnable_b;
	logic signed [IN_BITS-1:0] analogInPos, analogInNeg;
	logic [11:0] sampleData, capWord;
	logic sampleDataOe, wordValid, overRange, powerDownActive, wakeDone;
	logic [15:0] capCount, c0;
	int errCount, compares, n;
	int diffs[8] = '{-2048, -1024, -1, 0, 1024, 2047, 3000, -3000};
	pasout_top u_pasout_top (
		.core_clk        (core_clk),
		.rst_b           (rst_b),
		.analogInPos     (analogInPos),
		.analogInNeg     (analogInNeg),
		.lowPowerRequest (lowPowerRequest),
		.outEnable_b     (outEnable_b),
		.sampleData      (sampleData),
		.sampleDataOe    (sampleDataOe),
		.wordValid       (wordValid),
		.overRange       (overRange),
		.powerDownActive (powerDownActive),
		.wakeDone        (wakeDone)
	);
	pasout_capture u_pasout_capture (.core_clk(core_clk), .rst_b(rst_b),
		.sampleData(sampleData), .sampleDataOe(sampleDataOe),
		.wordValid(wordValid), .wakeDone(wakeDone),
		.capWord_ff(capWord), .capCount_ff(capCount));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errCount++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, errCount);
		if (errCount == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_wake;
		for (n = 0; n < 100 && wakeDone !== 1'b1; n++) tick(1);
		if (n == 100) begin
			errCount++;
			test_done;
		end
	endtask
	task automatic t_codes;
		int d;
		for (int i = 0; i < 8; i++) begin
			d = diffs[i];
			// Odd entries drive one side only, the other sits at mid level
			analogInNeg = IN_BITS'((i % 2) ? 0 : -d / 2);
			analogInPos = IN_BITS'(d) + analogInNeg;
			tick(12);
			check(capWord, d < -2048 ? 0 : d > 2047 ? 12'hFFF : d + 2048);
			check(overRange, d < -2048 || d > 2047);
		end
		$display("codes test done");
	endtask
	task automatic t_latency;
		analogInPos = 13'sh0000;
		analogInNeg = 13'sh0000;
		tick(12);
		analogInPos = 13'sh0400;
		for (n = 1; n < 20 && sampleData !== 12'hC00; n++) tick(1);
		// Two sync edges, the sampling edge and the loop start add four
		check(n, PIPE_LATENCY + 4);
		$display("latency test done");
	endtask
	task automatic t_ramp;
		c0 = capCount;
		for (int d = -2048; d < 2048; d++) begin
			analogInPos = IN_BITS'(d);
			tick(1);
		end
		tick(10);
		check(capCount - c0, 16'h100A);
		check(capWord, CODE_POS_FULL);
		$display("ramp test done");
	endtask
	task automatic t_oe;
		outEnable_b = 1'b1;
		tick(5);
		c0 = capCount;
		check(sampleDataOe, 0);
		tick(8);
		check(wordValid, 1);
		check(capCount - c0, 0);
		outEnable_b = 1'b0;
		tick(5);
		check(sampleDataOe, 1);
		$display("enable test done");
	endtask
	task automatic t_pd;
		lowPowerRequest = 1'b1;
		tick(6);
		check(powerDownActive, 1);
		check(wordValid, 0);
		lowPowerRequest = 1'b0;
		tick(1);
		check(wakeDone, 0);
		wait_wake;
		// One sync edge lies inside the wait
		check(n, WAKE_CYCLES + 1);
		check(wordValid, 1);
		$display("power-down test done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		rst_b = 1'b0;
		lowPowerRequest = 1'b0;
		outEnable_b = 1'b0;
		analogInPos = 13'sh0000;
		analogInNeg = 13'sh0000;
		tick(12);
		rst_b = 1'b1;
		wait_wake;
		t_codes;
		t_latency;
		t_ramp;
		t_oe;
		t_pd;
		test_done;
	end
endmodule
